/* logic/hib_defs.vh */
// constants of the host interrupt and buffer window block
`ifndef HIB_DEFS_VH
`define HIB_DEFS_VH
`define HIB_OFS_FRAME_LOW 16'hf0f6
`define HIB_OFS_FRAME_HIGH 16'hf0f7
`define HIB_OFS_MASK 16'hf0fb
`define HIB_OFS_FLAGS 16'hf0fc
`define HIB_OFS_PAGE 16'hf0ff
`define HIB_RST_MASK 8'h00
`define HIB_RST_FLAGS 8'h00
`define HIB_RST_FRAME 11'h000
`define HIB_RST_PAGE 7'h00
`define HIB_LATCH_RELEASE 8'h00
`define HIB_BIT_FRAME_STORED 0
`define HIB_BIT_LAST_FRAME_START 1
`define HIB_BIT_FRONTEND_OVERLENGTH 2
`define HIB_BIT_HEADER_READY 3
`define HIB_BIT_CORRECTION_DONE 4
`define HIB_BIT_FRONTEND_RECEIVE 5
`define HIB_BIT_FRONTEND_TRANSMIT 6
`define HIB_BIT_HOST_INTERFACE_UNIT 7
`define HIB_LINEAR_TOP 4'h7
`define HIB_WIN0 4'h8
`define HIB_WIN1 4'h9
`define HIB_WIN2 4'ha
`define HIB_REG_SPACE 4'hf
`define HIB_CMD_SYNDROME 3'h0
`define HIB_CMD_CRC 3'h1
`define HIB_CMD_COPY 3'h2
`define HIB_CMD_P_CORRECT 3'h3
`define HIB_CMD_Q_CORRECT 3'h4
`define HIB_CMD_ROM_TEST 3'h5
`define HIB_CMD_RAM_READ 3'h6
`define HIB_CMD_RAM_WRITE 3'h7
`define HIB_SYN_CYC 16'd5604
`define HIB_SYN_ACC 16'd2658
`define HIB_SYN_F1_CYC 16'd5600
`define HIB_SYN_F1_ACC 16'd2654
`define HIB_CRC_CYC 16'd4136
`define HIB_CRC_ACC 16'd2068
`define HIB_CRC_F1_CYC 16'd4120
`define HIB_CRC_F1_ACC 16'd2060
`define HIB_COPY_CYC 16'd1148
`define HIB_COPY_ACC 16'd574
`define HIB_COPY_F1_CYC 16'd1156
`define HIB_COPY_F1_ACC 16'd578
`define HIB_P_BASE_CYC 16'd1466
`define HIB_P_PER_CORR 16'd157
`define HIB_Q_BASE_CYC 16'd888
`define HIB_Q_PER_CORR 16'd167
`define HIB_ACC_PER_CORR 16'd2
`define HIB_RAM_CYC 16'd1184
`define HIB_RAM_ACC 16'd592
`define HIB_ROM_CYC 16'd1024
`define HIB_ACC_PERIOD_PLAIN 3'd2
`define HIB_ACC_PERIOD_PQ 3'd7
`endif

/* logic/hib_ecc_timer.v */
// ecc command run timer: paces buffer accesses and pulses completion
`timescale 1ns/100ps
`default_nettype none
`include "hib_defs.vh"
module hib_ecc_timer #(
	parameter [15:0] SYN_CYCLES = `HIB_SYN_CYC,
	parameter [15:0] SYN_F1_CYCLES = `HIB_SYN_F1_CYC,
	parameter [15:0] CRC_CYCLES = `HIB_CRC_CYC,
	parameter [15:0] CRC_F1_CYCLES = `HIB_CRC_F1_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire start,
	input wire [2:0] code,
	input wire form1,
	input wire abort,
	input wire [7:0] corrections,
	output wire busy,
	output reg access_q,
	output reg done_q
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RUN = 2'b10;
	reg [1:0] st_q;
	reg [15:0] cyc_q;
	reg [15:0] acc_q;
	reg [2:0] per_q;
	reg [2:0] period_q;
	reg [15:0] cyc_d;
	reg [15:0] acc_d;
	reg [2:0] period_d;
	wire [15:0] ncorr = {8'h00, corrections};
	always @* begin
		cyc_d = `HIB_RAM_CYC;
		acc_d = `HIB_RAM_ACC;
		period_d = `HIB_ACC_PERIOD_PLAIN;
		case (code)
		`HIB_CMD_SYNDROME: begin
			cyc_d = form1 ? SYN_F1_CYCLES : SYN_CYCLES;
			acc_d = form1 ? `HIB_SYN_F1_ACC : `HIB_SYN_ACC;
		end
		`HIB_CMD_CRC: begin
			cyc_d = form1 ? CRC_F1_CYCLES : CRC_CYCLES;
			acc_d = form1 ? `HIB_CRC_F1_ACC : `HIB_CRC_ACC;
		end
		`HIB_CMD_COPY: begin
			cyc_d = form1 ? `HIB_COPY_F1_CYC : `HIB_COPY_CYC;
			acc_d = form1 ? `HIB_COPY_F1_ACC : `HIB_COPY_ACC;
		end
		`HIB_CMD_P_CORRECT: begin
			cyc_d = `HIB_P_BASE_CYC + ncorr * `HIB_P_PER_CORR;
			acc_d = ncorr * `HIB_ACC_PER_CORR;
			period_d = `HIB_ACC_PERIOD_PQ;
		end
		`HIB_CMD_Q_CORRECT: begin
			cyc_d = `HIB_Q_BASE_CYC + ncorr * `HIB_Q_PER_CORR;
			acc_d = ncorr * `HIB_ACC_PER_CORR;
			period_d = `HIB_ACC_PERIOD_PQ;
		end
		`HIB_CMD_ROM_TEST: begin
			cyc_d = `HIB_ROM_CYC;
			acc_d = 16'h0000;
		end
		default: begin
			cyc_d = `HIB_RAM_CYC;
			acc_d = `HIB_RAM_ACC;
		end
		endcase
	end
	assign busy = st_q[1];
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			cyc_q <= 16'h0000;
			acc_q <= 16'h0000;
			per_q <= 3'h0;
			period_q <= `HIB_ACC_PERIOD_PLAIN;
			access_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			access_q <= 1'b0;
			done_q <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				if (start && !abort) begin
					st_q <= ST_RUN;
					cyc_q <= cyc_d;
					acc_q <= acc_d;
					period_q <= period_d;
					per_q <= 3'h1;
				end
			end
			ST_RUN: begin
				// abort stops quietly, no completion pulse
				if (abort) begin
					st_q <= ST_IDLE;
				end else begin
					cyc_q <= cyc_q - 16'h0001;
					if (per_q == period_q) begin
						per_q <= 3'h1;
						if (acc_q != 16'h0000) begin
							access_q <= 1'b1;
							acc_q <= acc_q - 16'h0001;
						end
					end else begin
						per_q <= per_q + 3'h1;
					end
					if (cyc_q <= 16'h0001) begin
						done_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // hib_ecc_timer
`default_nettype wire

/* logic/hib_top.v */
// microcontroller interrupt flags, mask and buffer address windows
// Behaviour
// - pulse completion interrupt when any ecc command finishes, either sector form.
// - syndrome calculation takes 5604 cycles, 5600 for form 1 sectors.
// - crc recompute takes 4136 cycles, 4120 for form 1 sectors.
// - results copy takes 1148 cycles, 1156 for form 1 sectors.
// - p and q correction use seven cycles per access, plus per-correction cost.
// - other commands use two cycles per buffer access.
// - reset clears mask and flag registers.
// - reset sets interrupt latch; writing 0x00 to flags releases it.
// - flag bits stay set until a zero is written to them.
// - events are recorded even while their mask bit is clear.
// - mask bit n gates flag bit n.
// - interrupt asserted while any unmasked flag is set.
// - flag bits map frame stored up to host interface unit events.
// - frame window uses low twelve address bits as offset in frame.
// - linear window address is low fifteen bits plus page times 32768.
// - frame counter loads on high byte write; low byte goes first.
// - counter load waits until a frame-counter dram access completes.
// - frame window address is frame number times 3072 plus offset.
// - second and third windows address the next one and two frames.
// - frames past the last pointer wrap to the start pointer.
`timescale 1ns/100ps
`default_nettype none
`include "hib_defs.vh"
module hib_top #(
	parameter [15:0] SYN_CYCLES = `HIB_SYN_CYC,
	parameter [15:0] SYN_F1_CYCLES = `HIB_SYN_F1_CYC,
	parameter [15:0] CRC_CYCLES = `HIB_CRC_CYC,
	parameter [15:0] CRC_F1_CYCLES = `HIB_CRC_F1_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire [15:0] mc_addr,
	input wire [7:0] mc_wdata,
	input wire mc_wr,
	input wire mc_rd,
	output reg [7:0] mc_rdata_q,
	output wire mc_wait,
	output reg mc_int_q,
	input wire evt_frame_stored,
	input wire evt_last_frame_start,
	input wire evt_frontend_overlength,
	input wire evt_header_ready,
	input wire evt_frontend_receive,
	input wire evt_frontend_transmit,
	input wire evt_host_interface_unit,
	input wire ecc_cmd_start,
	input wire [2:0] ecc_cmd_code,
	input wire ecc_form1,
	input wire ecc_abort,
	input wire [7:0] ecc_corrections,
	output wire ecc_busy,
	output wire ecc_access,
	output wire ecc_done,
	input wire [10:0] start_frame,
	input wire [10:0] last_frame_pointer,
	input wire buf_frame_busy,
	output reg buf_req_q,
	output reg buf_we_q,
	output reg [21:0] buf_addr_q,
	output reg [7:0] buf_wdata_q,
	input wire buf_ack,
	input wire [7:0] buf_rdata
);
	reg [7:0] interrupt_enable_mask_q;
	reg [7:0] interrupt_event_flags_q;
	reg [7:0] interrupt_event_flags_d;
	reg latch_q;
	reg latch_d;
	reg [7:0] frame_low_q;
	reg [2:0] frame_high_q;
	reg load_pend_q;
	reg [10:0] host_frame_number_q;
	reg [6:0] linear_page_select_q;
	reg pend_q;
	reg pend_frame_q;
	reg pend_rd_q;
	wire [3:0] region = mc_addr[15:12];
	wire is_reg = (region == `HIB_REG_SPACE);
	wire is_linear = (region <= `HIB_LINEAR_TOP);
	wire is_frame = (region == `HIB_WIN0) || (region == `HIB_WIN1) || (region == `HIB_WIN2);
	wire is_buf = is_linear || is_frame;
	wire wr_mask = mc_wr && (mc_addr == `HIB_OFS_MASK);
	wire wr_flags = mc_wr && (mc_addr == `HIB_OFS_FLAGS);
	wire wr_low = mc_wr && (mc_addr == `HIB_OFS_FRAME_LOW);
	wire wr_high = mc_wr && (mc_addr == `HIB_OFS_FRAME_HIGH);
	wire wr_page = mc_wr && (mc_addr == `HIB_OFS_PAGE);
	wire buf_start = (mc_wr || mc_rd) && is_buf && !pend_q;
	wire [7:0] events;
	wire frame_counter_busy;
	wire [1:0] win_step;
	wire [10:0] win_frame;
	wire [22:0] frame_base;
	wire [21:0] frame_addr;
	wire [21:0] linear_addr;
	reg [7:0] reg_rdata;

	// step past the programmed frame with wrap to the start pointer
	function [10:0] hib_advance;
		input [10:0] base;
		input [1:0] step;
		input [10:0] first;
		input [10:0] last;
		reg [11:0] sum;
		reg [11:0] over;
		begin
			sum = {1'b0, base} + {10'h000, step};
			over = sum - {1'b0, last} - 12'h001;
			if (sum > {1'b0, last}) begin
				hib_advance = first + over[10:0];
			end else begin
				hib_advance = sum[10:0];
			end
		end
	endfunction

	assign events[`HIB_BIT_FRAME_STORED] = evt_frame_stored;
	assign events[`HIB_BIT_LAST_FRAME_START] = evt_last_frame_start;
	assign events[`HIB_BIT_FRONTEND_OVERLENGTH] = evt_frontend_overlength;
	assign events[`HIB_BIT_HEADER_READY] = evt_header_ready;
	assign events[`HIB_BIT_CORRECTION_DONE] = ecc_done;
	assign events[`HIB_BIT_FRONTEND_RECEIVE] = evt_frontend_receive;
	assign events[`HIB_BIT_FRONTEND_TRANSMIT] = evt_frontend_transmit;
	assign events[`HIB_BIT_HOST_INTERFACE_UNIT] = evt_host_interface_unit;

	always @* begin
		interrupt_event_flags_d = interrupt_event_flags_q;
		if (wr_flags) begin
			interrupt_event_flags_d = interrupt_event_flags_q & mc_wdata;
		end
		interrupt_event_flags_d = interrupt_event_flags_d | events;
	end

	always @* begin
		latch_d = latch_q;
		if (wr_flags && (mc_wdata == `HIB_LATCH_RELEASE)) begin
			latch_d = 1'b0;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			interrupt_enable_mask_q <= `HIB_RST_MASK;
			interrupt_event_flags_q <= `HIB_RST_FLAGS;
			latch_q <= 1'b1;
			mc_int_q <= 1'b1;
		end else begin
			if (wr_mask) begin
				interrupt_enable_mask_q <= mc_wdata;
			end
			interrupt_event_flags_q <= interrupt_event_flags_d;
			latch_q <= latch_d;
			mc_int_q <= latch_d | (|(interrupt_event_flags_d & interrupt_event_flags_mask(wr_mask)));
		end
	end

	// mask value taking effect in the same cycle it is written
	function [7:0] interrupt_event_flags_mask;
		input sel;
		begin
			interrupt_event_flags_mask = sel ? mc_wdata : interrupt_enable_mask_q;
		end
	endfunction

	// the counter is in use while our own frame access is outstanding
	assign frame_counter_busy = buf_frame_busy || (pend_q && pend_frame_q);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_low_q <= 8'h00;
			frame_high_q <= 3'h0;
			load_pend_q <= 1'b0;
			host_frame_number_q <= `HIB_RST_FRAME;
			linear_page_select_q <= `HIB_RST_PAGE;
		end else begin
			if (wr_low) begin
				frame_low_q <= mc_wdata;
			end
			if (wr_high) begin
				frame_high_q <= mc_wdata[2:0];
				load_pend_q <= 1'b1;
			end else if (load_pend_q && !frame_counter_busy) begin
				load_pend_q <= 1'b0;
			end
			if (load_pend_q && !wr_high && !frame_counter_busy) begin
				host_frame_number_q <= {frame_high_q, frame_low_q};
			end
			if (wr_page) begin
				linear_page_select_q <= mc_wdata[6:0];
			end
		end
	end

	assign win_step = mc_addr[13:12] - 2'b00;
	assign win_frame = hib_advance(host_frame_number_q, win_step, start_frame,
		last_frame_pointer);
	assign frame_base = {1'b0, win_frame, 11'h000} + {2'b00, win_frame, 10'h000};
	assign frame_addr = frame_base[21:0] + {10'h000, mc_addr[11:0]};
	assign linear_addr = {linear_page_select_q, mc_addr[14:0]};

	assign mc_wait = pend_q;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_req_q <= 1'b0;
			buf_we_q <= 1'b0;
			buf_addr_q <= 22'h000000;
			buf_wdata_q <= 8'h00;
			pend_q <= 1'b0;
			pend_frame_q <= 1'b0;
			pend_rd_q <= 1'b0;
		end else begin
			buf_req_q <= 1'b0;
			if (buf_start) begin
				buf_req_q <= 1'b1;
				buf_we_q <= mc_wr;
				buf_wdata_q <= mc_wdata;
				buf_addr_q <= is_frame ? frame_addr : linear_addr;
				pend_q <= 1'b1;
				pend_frame_q <= is_frame;
				pend_rd_q <= mc_rd;
			end else if (pend_q && buf_ack) begin
				pend_q <= 1'b0;
				pend_frame_q <= 1'b0;
				pend_rd_q <= 1'b0;
			end
		end
	end

	always @* begin
		reg_rdata = 8'h00;
		case (mc_addr)
		`HIB_OFS_FRAME_LOW: reg_rdata = frame_low_q;
		`HIB_OFS_FRAME_HIGH: reg_rdata = {5'h00, host_frame_number_q[10:8]};
		`HIB_OFS_MASK: reg_rdata = interrupt_enable_mask_q;
		`HIB_OFS_FLAGS: reg_rdata = interrupt_event_flags_q;
		`HIB_OFS_PAGE: reg_rdata = {1'b0, linear_page_select_q};
		default: reg_rdata = 8'h00;
		endcase
	end

	// unused space and unmapped registers read zero
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mc_rdata_q <= 8'h00;
		end else if (pend_q && pend_rd_q && buf_ack) begin
			mc_rdata_q <= buf_rdata;
		end else if (mc_rd && is_reg) begin
			mc_rdata_q <= reg_rdata;
		end else if (mc_rd && !is_buf) begin
			mc_rdata_q <= 8'h00;
		end
	end

	hib_ecc_timer #(
		.SYN_CYCLES(SYN_CYCLES),
		.SYN_F1_CYCLES(SYN_F1_CYCLES),
		.CRC_CYCLES(CRC_CYCLES),
		.CRC_F1_CYCLES(CRC_F1_CYCLES)
	) u_ecc (
		.clk(clk),
		.rst_b(rst_b),
		.start(ecc_cmd_start),
		.code(ecc_cmd_code),
		.form1(ecc_form1),
		.abort(ecc_abort),
		.corrections(ecc_corrections),
		.busy(ecc_busy),
		.access_q(ecc_access),
		.done_q(ecc_done)
	);
endmodule // hib_top
`default_nettype wire

/* sim/hib_top_props.sv */
// concurrent checks on the ports of the interrupt and buffer window block
`timescale 1ns/100ps
`default_nettype none
`include "hib_defs.vh"
module hib_top_props #(
	parameter [15:0] SYN_CYCLES = `HIB_SYN_CYC,
	parameter [15:0] SYN_F1_CYCLES = `HIB_SYN_F1_CYC,
	parameter [15:0] CRC_CYCLES = `HIB_CRC_CYC,
	parameter [15:0] CRC_F1_CYCLES = `HIB_CRC_F1_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] mc_addr,
	input wire logic mc_wr,
	input wire logic mc_rd,
	input wire logic mc_wait,
	input wire logic mc_int_q,
	input wire logic ecc_cmd_start,
	input wire logic [2:0] ecc_cmd_code,
	input wire logic ecc_form1,
	input wire logic ecc_abort,
	input wire logic ecc_busy,
	input wire logic ecc_access,
	input wire logic ecc_done,
	input wire logic buf_req_q,
	input wire logic [21:0] buf_addr_q,
	input wire logic buf_ack
);
	// done is a register set at the nth edge, so it is sampled one edge later
	localparam int SYN_N = SYN_CYCLES + 1;
	localparam int CRC_N = CRC_CYCLES + 1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire take = ecc_cmd_start && !ecc_busy && !ecc_abort && !ecc_form1;
	wire win = (mc_rd || mc_wr) && !mc_wait;
	property p_done_pulse; ecc_done |=> !ecc_done; endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("completion pulse longer than one clock");
	property p_done_busy; ecc_done |-> $past(ecc_busy); endproperty
	a_done_busy: assert property (p_done_busy)
		else $error("completion without a running command");
	property p_syn; take && ecc_cmd_code == `HIB_CMD_SYNDROME |-> ##SYN_N ecc_done; endproperty
	a_syn: assert property (p_syn)
		else $error("syndrome run length wrong");
	property p_crc; take && ecc_cmd_code == `HIB_CMD_CRC |-> ##CRC_N ecc_done; endproperty
	a_crc: assert property (p_crc)
		else $error("crc run length wrong");
	property p_acc_space; ecc_access |=> !ecc_access; endproperty
	a_acc_space: assert property (p_acc_space)
		else $error("buffer accesses closer than two cycles");
	property p_rst_int; $rose(rst_b) |-> mc_int_q; endproperty
	a_rst_int: assert property (p_rst_int)
		else $error("interrupt latch not set by reset");
	property p_int_fall;
		$fell(mc_int_q) |-> $past(mc_wr && (mc_addr == `HIB_OFS_FLAGS || mc_addr == `HIB_OFS_MASK));
	endproperty
	a_int_fall: assert property (p_int_fall)
		else $error("interrupt dropped without a flag or mask write");
	property p_lin; win && !mc_addr[15] |=> buf_req_q && buf_addr_q[14:0] == $past(mc_addr[14:0]);
	endproperty
	a_lin: assert property (p_lin)
		else $error("linear window address wrong");
	property p_frm;
		win && mc_addr[15:12] inside {4'h8, 4'h9, 4'ha}
		|=> buf_req_q && (buf_addr_q % 22'd3072) == {10'h000, $past(mc_addr[11:0])};
	endproperty
	a_frm: assert property (p_frm)
		else $error("frame window offset wrong");
	c_done: cover property (ecc_done);
	c_int_fall: cover property ($fell(mc_int_q));
	c_ack: cover property (buf_req_q ##[1:20] buf_ack);
endmodule // hib_top_props
bind hib_top hib_top_props #(.SYN_CYCLES(SYN_CYCLES), .SYN_F1_CYCLES(SYN_F1_CYCLES),
	.CRC_CYCLES(CRC_CYCLES), .CRC_F1_CYCLES(CRC_F1_CYCLES)) i_props (.clk, .rst_b,
	.mc_addr, .mc_wr, .mc_rd, .mc_wait, .mc_int_q, .ecc_cmd_start, .ecc_cmd_code,
	.ecc_form1, .ecc_abort, .ecc_busy, .ecc_access, .ecc_done, .buf_req_q,
	.buf_addr_q, .buf_ack);
`default_nettype wire

/* sim/hib_buffer_model.sv */
// behavioural dram buffer answering the block's buffer requests
`timescale 1ns/100ps
`default_nettype none
module hib_buffer_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic req,
	input wire logic we,
	input wire logic [21:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [3:0] lat,
	output logic ack,
	output logic [7:0] rdata
);
	logic [7:0] mem [int];
	logic [7:0] v;
	logic [7:0] last;
	logic [3:0] cnt;
	logic pend;
	logic we_q;
	logic [21:0] a_q;
	logic [7:0] d_q;
	// unwritten cells read their own low address byte so wrong addresses show
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			pend <= 1'b0;
			rdata <= 8'h00;
			last = 8'h00;
		end else begin
			ack <= 1'b0;
			// read data is not held after the answer
			rdata <= ~last;
			if (req) begin
				pend <= 1'b1;
				cnt <= lat;
				a_q <= addr;
				we_q <= we;
				d_q <= wdata;
			end else if (pend && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (pend) begin
				pend <= 1'b0;
				ack <= 1'b1;
				if (we_q)
					mem[a_q] = d_q;
				v = mem.exists(a_q) ? mem[a_q] : a_q[7:0];
				rdata <= v;
				last = v;
			end
		end
	end
endmodule // hib_buffer_model
`default_nettype wire

/* sim/hib_top_tb.sv */
// self-checking bench for the interrupt flags, ecc timing and buffer windows
`timescale 1ns/100ps
`default_nettype none
`include "hib_defs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module hib_top_tb;
	logic clk, rst_b, mc_wr, mc_rd, mc_wait, mc_int_q, ecc_cmd_start, ecc_form1, ecc_abort;
	logic ecc_busy, ecc_access, ecc_done, buf_frame_busy, buf_req_q, buf_we_q, buf_ack;
	logic [15:0] mc_addr;
	logic [7:0] mc_wdata, mc_rdata_q, ev, ecc_corrections, buf_wdata_q, buf_rdata;
	logic [2:0] ecc_cmd_code;
	logic [10:0] start_frame, last_frame_pointer;
	logic [21:0] buf_addr_q, ba;
	logic [3:0] lat;
	int num_errors, total_checks, n, acc;
	hib_top #(.SYN_CYCLES(16'd40), .SYN_F1_CYCLES(16'd38), .CRC_CYCLES(16'd30),
		.CRC_F1_CYCLES(16'd28)) i_dut (.clk, .rst_b, .mc_addr, .mc_wdata, .mc_wr, .mc_rd,
		.mc_rdata_q, .mc_wait, .mc_int_q, .evt_frame_stored(ev[0]),
		.evt_last_frame_start(ev[1]), .evt_frontend_overlength(ev[2]),
		.evt_header_ready(ev[3]), .evt_frontend_receive(ev[5]),
		.evt_frontend_transmit(ev[6]), .evt_host_interface_unit(ev[7]), .ecc_cmd_start,
		.ecc_cmd_code, .ecc_form1, .ecc_abort, .ecc_corrections, .ecc_busy, .ecc_access,
		.ecc_done, .start_frame, .last_frame_pointer, .buf_frame_busy, .buf_req_q, .buf_we_q,
		.buf_addr_q, .buf_wdata_q, .buf_ack, .buf_rdata);
	hib_buffer_model i_buf (.clk, .rst_b, .req(buf_req_q), .we(buf_we_q), .addr(buf_addr_q),
		.wdata(buf_wdata_q), .lat, .ack(buf_ack), .rdata(buf_rdata));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic acc_bus(input logic [15:0] a, input logic [7:0] d, input logic w);
		int k;
		k = 0;
		mc_addr = a;
		mc_wdata = d;
		mc_wr = w;
		mc_rd = !w;
		@(negedge clk);
		mc_wr = 1'b0;
		mc_rd = 1'b0;
		while (mc_wait === 1'b1 && k < 50) begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		acc_bus(a, d, 1'b1);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		acc_bus(a, 8'h00, 1'b0);
		`CHK(mc_rdata_q, e)
	endtask
	task automatic ecc(input logic [2:0] c, input logic f, input int cyc, input int ea);
		ecc_cmd_code = c;
		ecc_form1 = f;
		ecc_cmd_start = 1'b1;
		n = 0;
		acc = 0;
		while (ecc_done !== 1'b1 && n < 3000) begin
			@(negedge clk);
			ecc_cmd_start = 1'b0;
			n++;
			if (ecc_access === 1'b1)
				acc++;
		end
		// the first falling edge counted already lies after the take edge
		`CHK(n - 1, cyc)
		if (ea >= 0)
			`CHK(acc, ea)
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		print_verdict;
	end
	initial begin
		{rst_b, mc_wr, mc_rd, ecc_cmd_start, ecc_form1, ecc_abort, buf_frame_busy} = 7'h00;
		{mc_addr, mc_wdata, ev, ecc_cmd_code, lat} = 39'h0;
		ecc_corrections = 8'h01;
		start_frame = 11'h002;
		last_frame_pointer = 11'h011;
		num_errors = 0;
		total_checks = 0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		`CHK(mc_int_q, 1'b1)
		rdc(`HIB_OFS_MASK, 8'h00);
		rdc(`HIB_OFS_FLAGS, 8'h00);
		rdc(16'hf0f0, 8'h00);
		wr(`HIB_OFS_FLAGS, 8'h00);
		`CHK(mc_int_q, 1'b0)
		for (int i = 0; i < 8; i++) if (i != 4) begin
			ev[i] = 1'b1;
			@(negedge clk);
			ev = 8'h00;
			rdc(`HIB_OFS_FLAGS, 8'h01 << i);
			`CHK(mc_int_q, 1'b0)
			wr(`HIB_OFS_MASK, 8'h01 << i);
			`CHK(mc_int_q, 1'b1)
			wr(`HIB_OFS_FLAGS, 8'hff);
			rdc(`HIB_OFS_FLAGS, 8'h01 << i);
			wr(`HIB_OFS_FLAGS, ~(8'h01 << i));
			rdc(`HIB_OFS_FLAGS, 8'h00);
			`CHK(mc_int_q, 1'b0)
			wr(`HIB_OFS_MASK, 8'h00);
		end
		// event and clearing write land on the same edge
		ev[0] = 1'b1;
		wr(`HIB_OFS_FLAGS, 8'h00);
		ev = 8'h00;
		rdc(`HIB_OFS_FLAGS, 8'h01);
		wr(`HIB_OFS_FLAGS, 8'h00);
		for (int k = 0; k < 11; k++) begin
			ecc(k < 6 ? k / 2 : k - 3, k < 6 ? k % 2 : 0,
				k == 0 ? 40 : k == 1 ? 38 : k == 2 ? 30 : k == 3 ? 28 : k == 4 ? 1148 :
				k == 5 ? 1156 : k == 6 ? 1623 : k == 7 ? 1055 : k == 8 ? 1024 : 1184,
				k < 4 ? -1 : k == 4 ? 574 : k == 5 ? 578 : k < 8 ? 2 : k == 8 ? 0 : 592);
			@(negedge clk);
			rdc(`HIB_OFS_FLAGS, 8'h10);
			wr(`HIB_OFS_FLAGS, 8'h00);
		end
		ecc_cmd_code = `HIB_CMD_COPY;
		ecc_cmd_start = 1'b1;
		repeat (10) @(negedge clk);
		ecc_cmd_start = 1'b0;
		// abort in mid run, no completion pulse follows
		ecc_abort = 1'b1;
		@(negedge clk);
		ecc_abort = 1'b0;
		acc = 0;
		repeat (1200) begin
			@(negedge clk);
			if (ecc_done === 1'b1)
				acc++;
		end
		`CHK(acc, 0)
		`CHK(ecc_busy, 1'b0)
		wr(`HIB_OFS_PAGE, 8'hff);
		rdc(`HIB_OFS_PAGE, 8'h7f);
		wr(`HIB_OFS_PAGE, 8'h05);
		lat = 4'h6;
		wr(16'h1234, 8'h3c);
		rdc(16'h1234, 8'h3c);
		`CHK(buf_addr_q, {7'h05, 15'h1234})
		lat = 4'h0;
		wr(`HIB_OFS_FRAME_LOW, 8'h10);
		wr(`HIB_OFS_FRAME_HIGH, 8'h00);
		rdc(`HIB_OFS_FRAME_LOW, 8'h10);
		for (int k = 0; k < 3; k++) begin
			ba = (k < 2 ? 16 + k : 2) * 3072 + 12'habc;
			rdc(16'h8abc + k * 16'h1000, ba[7:0]);
			`CHK(buf_addr_q, ba)
		end
		buf_frame_busy = 1'b1;
		wr(`HIB_OFS_FRAME_HIGH, 8'h01);
		repeat (3) @(negedge clk);
		rdc(`HIB_OFS_FRAME_HIGH, 8'h00);
		buf_frame_busy = 1'b0;
		repeat (2) @(negedge clk);
		rdc(`HIB_OFS_FRAME_HIGH, 8'h01);
		print_verdict;
	end
endmodule // hib_top_tb
`default_nettype wire
